/* sim/float_dataflow_block_handshake_tb.sv */
// Testbench joining user end and block through the link
`timescale 1ns/1ps
module float_dataflow_block_handshake_tb
  import flow_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [IN_PORTS-1:0][SINGLE_WIDTH-1:0] op_data;
  logic [IN_PORTS-1:0] op_valid;
  logic [IN_PORTS-1:0] op_ready;
  logic [SINGLE_WIDTH-1:0] res_data;
  logic res_valid;
  logic res_ready;
  int n_fail = 0;
  int total_checks = 0;
  flow_if flow_if_i();
  user_end user_end_i(.clk_in(clk_in), .reset_in(reset_in),
    .op_data_in(op_data), .op_valid_in(op_valid), .op_ready_out(op_ready),
    .res_data_out(res_data), .res_valid_out(res_valid),
    .res_ready_in(res_ready), .link(flow_if_i.user));
  calc_block calc_block_i(.clk_in(clk_in), .reset_in(reset_in),
    .link(flow_if_i.block));
  flow_sva flow_sva_i(.clk_in(clk_in), .reset_in(reset_in),
    .in_data(flow_if_i.in_data), .in_valid(flow_if_i.in_valid),
    .in_ready(flow_if_i.in_ready), .res_data(flow_if_i.res_data),
    .res_valid(flow_if_i.res_valid), .res_ready(flow_if_i.res_ready));
  always #4 clk_in = ~clk_in;
  function automatic logic [31:0] val(int p, int i);
    return p ? 32'h00010000 * i + 32'h000000A0 :
               32'h01000000 * i + 32'h00000003;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Mode 0 free flow, 1 long stall, 2 gaps on every side
  task automatic run(int n, int mode);
    int ix [2];
    int rx;
    logic [1:0] tk;
    logic tr;
    logic blk;
    ix = '{0, 0};
    rx = 0;
    blk = 1'b0;
    for (int c = 0; c < 600 && rx < n; c++) begin
      for (int j = 0; j < 2; j++) begin
        op_valid[j] = ix[j] < n && (mode != 2 || (c % (j + 2)) != 0);
        op_data[j] = val(j, ix[j]);
      end
      res_ready = mode == 0 || (mode == 1 && c > 40) || (mode == 2 && c[0]);
      #1;
      tk = op_valid & op_ready;
      tr = res_valid && res_ready;
      if (!op_ready[0]) blk = 1'b1;
      if (tr) check(res_data, 2 * val(0, rx) + val(1, rx));
      @(posedge clk_in);
      for (int j = 0; j < 2; j++) ix[j] += int'(tk[j]);
      rx += int'(tr);
      @(negedge clk_in);
    end
    op_valid = 2'h0;
    if (rx < n) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, 32'(rx), 32'(n));
      give_verdict();
    end
    // Full buffers must refuse
    if (mode == 1) check(32'(blk), 32'h00000001);
    check(32'(res_valid), 32'h00000000);
  endtask
  initial begin
    op_data = '0;
    op_valid = 2'h0;
    res_ready = 1'b0;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
    run(12, 0);
    run(12, 1);
    run(10, 2);
    give_verdict();
  end
endmodule // float_dataflow_block_handshake_tb

/* sim/flow_sva.sv */
// Handshake checker on the link between user end and block
`timescale 1ns/1ps
module flow_sva
  import flow_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [IN_PORTS-1:0][SINGLE_WIDTH-1:0] in_data,
  input wire logic [IN_PORTS-1:0] in_valid,
  input wire logic [IN_PORTS-1:0] in_ready,
  input wire logic [OUT_PORTS-1:0][SINGLE_WIDTH-1:0] res_data,
  input wire logic [OUT_PORTS-1:0] res_valid,
  input wire logic [OUT_PORTS-1:0] res_ready
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Port 0 takes minus pops, words in flight
  logic [4:0] occ_reg;
  wire logic take0 = in_valid[0] && in_ready[0];
  wire logic pop = res_valid[0] && res_ready[0];
  always_ff @(posedge clk_in) begin
    if (reset_in) occ_reg <= 5'h00;
    else occ_reg <= occ_reg + 5'(take0) - 5'(pop);
  end
  property p_res_hold;
    res_valid[0] && !res_ready[0] |=> res_valid[0] && $stable(res_data);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result dropped");
  property p_in_hold0;
    in_valid[0] && !in_ready[0] |=> in_valid[0] && $stable(in_data[0]);
  endproperty
  a_in_hold0: assert property (p_in_hold0)
    else $error("port 0 dropped");
  property p_in_hold1;
    in_valid[1] && !in_ready[1] |=> in_valid[1] && $stable(in_data[1]);
  endproperty
  a_in_hold1: assert property (p_in_hold1)
    else $error("port 1 dropped");
  property p_clear;
    $fell(reset_in) |-> in_valid == 2'h0 && !res_valid[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("valid after reset");
  property p_rdy_rst;
    $fell(reset_in) |=> in_ready == 2'h3;
  endproperty
  a_rdy_rst: assert property (p_rdy_rst)
    else $error("not ready");
  property p_res_occ;
    res_valid[0] |-> occ_reg != 5'h00;
  endproperty
  a_res_occ: assert property (p_res_occ)
    else $error("result from nothing");
  property p_occ_max;
    occ_reg <= 5'h0C;
  endproperty
  a_occ_max: assert property (p_occ_max)
    else $error("no back-pressure");
  property p_latency;
    occ_reg == 5'h00 |-> !res_valid[0] ##1 !res_valid[0] [*2];
  endproperty
  a_latency: assert property (p_latency)
    else $error("result too early");
endmodule // flow_sva

/* src/calc_block.sv */
// Streaming computation block: wrapped adder with handshaked ports
// Overview of operation
// RQ1 - Each port has data, valid, ready
// RQ2 - Data width 32 or 64 at build
// RQ3 - User asserts valid only with valid data
// RQ4 - Block asserts ready when input can accept
// RQ5 - Block asserts result valid only when valid
// RQ6 - User asserts result ready when accepting
// RQ7 - Same index means same port everywhere
// RQ8 - Option: input ready only when all ready
// RQ9 - Output back-pressure propagates to inputs
// RQ10 - Back-pressure delay follows wrapper structure
// RQ11 - Operators joined through handshake wrappers
// RQ12 - Shared input combines consumer valid/ready
// RQ13 - Internal queues may delay timing
// RQ14 - Transfer only when valid and ready high
// RQ15 - Wrapper registers ready, holds result
// RQ16 - Wrapper input queues default depth two
`timescale 1ns/1ps
module calc_block
  import flow_pkg::*;
#(
  parameter int WIDTH = SINGLE_WIDTH,
  parameter int N_IN = IN_PORTS,
  parameter int QDEPTH = QUEUE_DEPTH,
  parameter int ODEPTH = OUT_FIFO_DEPTH,
  parameter bit ALL_READY = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  flow_if.block link
);
  // Operator: sum of all inputs, with first input also doubled by reuse:
  // input 0 feeds both the adder and a second (pass) consumer.
  logic [N_IN-1:0][WIDTH-1:0] q_data;
  logic [N_IN-1:0] q_valid;
  logic [N_IN-1:0] q_ready;
  logic [N_IN-1:0] q_wr_ready;
  logic [N_IN-1:0] port_valid;

  // RQ8 all-ready option
  wire all_ready = &q_wr_ready;
  // RQ4 RQ7 ready per index
  assign link.in_ready = ALL_READY ? {N_IN{all_ready}} : q_wr_ready;
  assign port_valid = ALL_READY ? (link.in_valid & {N_IN{all_ready}}) :
                      link.in_valid;

  // RQ16 depth-two input queues
  genvar i;
  generate
    for (i = 0; i < N_IN; i++) begin : g_inq
      stream_fifo #(.WIDTH(WIDTH), .DEPTH(QDEPTH)) u_q (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_data_in(link.in_data[i]),
        .wr_valid_in(port_valid[i]),
        .wr_ready_out(q_wr_ready[i]),
        .rd_data_out(q_data[i]),
        .rd_valid_out(q_valid[i]),
        .rd_ready_in(q_ready[i])
      );
    end
  endgenerate

  // Stage one wrapper: adder, its registered ready and hold register
  logic ready_sync_reg;
  logic [WIDTH-1:0] hold_data_reg;
  logic hold_valid_reg;
  logic [WIDTH-1:0] op_data_reg;
  logic op_valid_reg;
  logic [WIDTH-1:0] sum_comb;
  logic [WIDTH-1:0] w1_data;
  logic w1_valid;
  logic w2_ready;
  // Second consumer of input 0: delay wrapper stage
  logic [WIDTH-1:0] pass_reg;
  logic pass_valid_reg;

  always_comb begin
    sum_comb = '0;
    for (int k = 0; k < N_IN; k++) begin
      sum_comb = sum_comb + q_data[k];
    end
  end

  // RQ12 shared input joins consumers
  wire consumers_ready = ready_sync_reg && (!pass_valid_reg || w2_ready);
  // RQ11 wrapper gating of operator inputs
  wire op_fire = (&q_valid) && consumers_ready && !hold_valid_reg;
  // RQ14 pop only on handshake
  assign q_ready = {N_IN{op_fire}};

  // RQ15 mux between live result and held copy
  assign w1_data = hold_valid_reg ? hold_data_reg : op_data_reg;
  assign w1_valid = hold_valid_reg || op_valid_reg;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      op_valid_reg <= 1'b0;
      op_data_reg <= WIDTH'(FILL_VALUE);
      pass_valid_reg <= 1'b0;
      pass_reg <= WIDTH'(FILL_VALUE);
    end else begin
      op_valid_reg <= op_fire;
      if (op_fire) begin
        op_data_reg <= sum_comb;
        pass_reg <= q_data[0];
      end
      if (op_fire) begin
        pass_valid_reg <= 1'b1;
      end else if (w2_ready) begin
        pass_valid_reg <= 1'b0;
      end
    end
  end

  // RQ15 registered ready and result hold
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ready_sync_reg <= 1'b0;
      hold_valid_reg <= 1'b0;
      hold_data_reg <= WIDTH'(FILL_VALUE);
    end else begin
      ready_sync_reg <= w2_ready;
      if (op_valid_reg && !w2_ready && !hold_valid_reg) begin
        hold_valid_reg <= 1'b1;
        hold_data_reg <= op_data_reg;
      end else if (w2_ready) begin
        hold_valid_reg <= 1'b0;
      end
    end
  end

  // Final combine: sum plus reused input 0, into output FIFO
  wire [WIDTH-1:0] final_data = w1_data + pass_reg;
  wire final_valid = w1_valid && pass_valid_reg;
  logic fifo_wr_ready;
  // RQ9 RQ10 RQ13 back-pressure through queue
  assign w2_ready = fifo_wr_ready;

  // RQ5 RQ14 output queue
  stream_fifo #(.WIDTH(WIDTH), .DEPTH(ODEPTH)) u_outq (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_data_in(final_data),
    .wr_valid_in(final_valid),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(link.res_data[0]),
    .rd_valid_out(link.res_valid[0]),
    .rd_ready_in(link.res_ready[0])
  );
endmodule // calc_block

/* src/flow_if.sv */
// Interface joining the user logic and the computation block
`timescale 1ns/1ps
interface flow_if #(
  parameter int WIDTH = flow_pkg::SINGLE_WIDTH,
  parameter int N_IN = flow_pkg::IN_PORTS,
  parameter int N_OUT = flow_pkg::OUT_PORTS
);
  logic [N_IN-1:0][WIDTH-1:0] in_data;
  logic [N_IN-1:0] in_valid;
  logic [N_IN-1:0] in_ready;
  logic [N_OUT-1:0][WIDTH-1:0] res_data;
  logic [N_OUT-1:0] res_valid;
  logic [N_OUT-1:0] res_ready;
  modport block (
    input in_data,
    input in_valid,
    output in_ready,
    output res_data,
    output res_valid,
    input res_ready
  );
  modport user (
    output in_data,
    output in_valid,
    input in_ready,
    input res_data,
    input res_valid,
    output res_ready
  );
endinterface

/* src/flow_pkg.sv */
// Shared constants for the streaming computation block and its user end
package flow_pkg;
  localparam int SINGLE_WIDTH = 32;
  localparam int DOUBLE_WIDTH = 64;
  localparam int IN_PORTS = 2;
  localparam int OUT_PORTS = 1;
  localparam int QUEUE_DEPTH = 2;
  localparam int OUT_FIFO_DEPTH = 4;
  localparam int FILL_VALUE = 0;
endpackage

/* src/stream_fifo.sv */
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module stream_fifo
  import flow_pkg::*;
#(
  parameter int WIDTH = SINGLE_WIDTH,
  parameter int DEPTH = OUT_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = wr_valid_in && wr_ready_out;
  wire pop = rd_valid_out && rd_ready_in;
  wire [AW-1:0] wr_ptr_inc = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 :
                             wr_ptr_reg + 1'b1;
  wire [AW-1:0] rd_ptr_inc = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 :
                             rd_ptr_reg + 1'b1;
  assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out = mem_reg[rd_ptr_reg];
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_inc;
      if (pop) rd_ptr_reg <= rd_ptr_inc;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // stream_fifo

/* src/user_end.sv */
// User-side end: feeds operands and consumes results
`timescale 1ns/1ps
module user_end
  import flow_pkg::*;
#(
  parameter int WIDTH = SINGLE_WIDTH,
  parameter int N_IN = IN_PORTS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [N_IN-1:0][WIDTH-1:0] op_data_in,
  input wire logic [N_IN-1:0] op_valid_in,
  output logic [N_IN-1:0] op_ready_out,
  output logic [WIDTH-1:0] res_data_out,
  output logic res_valid_out,
  input wire logic res_ready_in,
  flow_if.user link
);
  logic [N_IN-1:0][WIDTH-1:0] data_reg;
  logic [N_IN-1:0] valid_reg;
  logic [WIDTH-1:0] res_reg;
  logic res_valid_reg;
  // RQ3 RQ14 hold word until taken
  wire [N_IN-1:0] take = link.in_ready | ~valid_reg;
  assign op_ready_out = take;
  assign link.in_data = data_reg;
  assign link.in_valid = valid_reg;
  // RQ6 ready when slot free
  assign link.res_ready[0] = !res_valid_reg || res_ready_in;
  assign res_data_out = res_reg;
  assign res_valid_out = res_valid_reg;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      valid_reg <= '0;
      data_reg <= '0;
      res_valid_reg <= 1'b0;
      res_reg <= '0;
    end else begin
      for (int k = 0; k < N_IN; k++) begin
        if (take[k]) begin
          valid_reg[k] <= op_valid_in[k];
          data_reg[k] <= op_data_in[k];
        end
      end
      if (link.res_ready[0]) begin
        res_valid_reg <= link.res_valid[0];
        if (link.res_valid[0]) res_reg <= link.res_data[0];
      end
    end
  end
endmodule // user_end
